// *** sw_pkg.sv ***
// constants, register map and types of the standalone watchdog
package sw_pkg;
  // =====================================================
  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_KEY = 8'h00;
  localparam logic [7:0] OFF_DIV = 8'h04;
  localparam logic [7:0] OFF_RLD = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_WIN = 8'h10;
  // =====================================================
  // command keys
  localparam logic [15:0] KEY_UNLOCK = 16'h5555;
  localparam logic [15:0] KEY_RELOAD = 16'haaaa;
  localparam logic [15:0] KEY_START = 16'hcccc;
  // =====================================================
  // fields and reset values
  localparam int CNT_W = 12;
  localparam int DIV_W = 3;
  localparam int PRE_W = 8;
  localparam int KEY_LSB = 0;
  localparam int DIV_LSB = 0;
  localparam int RLD_LSB = 0;
  localparam int WIN_LSB = 0;
  localparam int STAT_DIV_BIT = 0;
  localparam int STAT_RLD_BIT = 1;
  localparam int STAT_WIN_BIT = 2;
  localparam logic [2:0] RST_DIV = 3'h0;
  localparam logic [11:0] RST_RLD = 12'hfff;
  localparam logic [11:0] RST_WIN = 12'hfff;
  localparam logic [31:0] RST_KEY = 32'h0;
  localparam logic [8:0] DIV_BASE = 9'h004;
  localparam logic [2:0] DIV_TOP_CODE = 3'h6;
  // =====================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int LSO_FREQ_HZ = 40000;
  localparam int LSO_PERIOD_NS = 1000000000 / LSO_FREQ_HZ;
  localparam int LSO_CYCLES = LSO_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [9:0] LSO_LAST = 10'(LSO_CYCLES - 1);
  localparam logic [1:0] SYNC_LAST = 2'h1;
  // =====================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef struct packed {
    logic [11:0] win;
    logic [11:0] reload_value;
    logic [2:0] div;
  } sw_cfg_t;
endpackage

// *** sw_watchdog.sv ***
// standalone watchdog with key commands over an axi4-lite slave
//
// Summary of operation
// R1: start key enables the watchdog; counter decrements on each prescaled tick.
// R2: enabled watchdog requests system reset when the counter reaches zero.
// R3: reload key reloads the counter at any time, keeping reset away unless the counter is above the window value.
// R4: reload takes its value from the programmed reload value field.
// R5: eight-stage prescaler feeds a twelve-bit down counter.
// R6: auto-start option bit starts the watchdog at power on without software.
// R7: divider, reload and window registers writable only after the unlock key.
// R8: any other command value restores write protection.
// R9: update in progress sets its busy bit; register read then returns invalid.
// R10: debug freeze set stops the counter while the core is halted.
// R11: divider code 0..5 gives 4..128, codes 6 and 7 give 256.
// R12: command field is sixteen bits, write only, upper bits reserved.
// R13: software waits for divider busy to clear before a second change.
// R14: each tick lasts divisor times 25 us from the 40 kHz source.
// R15: timing runs from its own low-speed oscillator tick.
// R16: reload value is twelve bits at 0x08, reset 0xfff.
// R17: status holds busy bits: 0 divider, 1 reload, 2 window.
// R18: reload while counter above window value requests reset.
// R19: protected writes are ignored and leave values unchanged.
// R20: busy bit clears once the new value reaches the counting side.
// R21: start loads the counter with the reload value first.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module sw_watchdog (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic auto_start_opt,
  input wire logic core_debug_halt,
  input wire logic debug_freeze,
  output logic system_reset_req,
  output logic watchdog_running
);
  // =====================================================
  // helpers
  function automatic logic [7:0] div_last(input logic [2:0] code);
    logic [8:0] d;
    d = sw_pkg::DIV_BASE << ((code > sw_pkg::DIV_TOP_CODE) ? sw_pkg::DIV_TOP_CODE : code);
    return 8'(d - 9'h001);
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction
  function automatic logic mapped(input logic [7:0] a);
    return (a == sw_pkg::OFF_KEY) || (a == sw_pkg::OFF_DIV) || (a == sw_pkg::OFF_RLD) ||
           (a == sw_pkg::OFF_WIN) || (a == sw_pkg::OFF_STAT);
  endfunction

  // =====================================================
  // axi4-lite write channel
  logic aw_rdy_q, w_rdy_q, aw_full_q, w_full_q, b_valid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] b_resp_q;
  wire aw_take = awvalid && aw_rdy_q;
  wire w_take = wvalid && w_rdy_q;
  wire wr_go = aw_full_q && w_full_q && !b_valid_q;
  wire [7:0] wa = aw_addr_q;
  wire wr_map = mapped(wa);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aw_rdy_q <= 1'b0;
      w_rdy_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= sw_pkg::RST_KEY;
      w_strb_q <= 4'h0;
    end else begin
      aw_rdy_q <= awvalid && !aw_rdy_q && !aw_full_q && !b_valid_q;
      w_rdy_q <= wvalid && !w_rdy_q && !w_full_q && !b_valid_q;
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= {awaddr[7:2], 2'b00};
      end else if (wr_go) begin
        aw_full_q <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (wr_go) begin
        w_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      b_valid_q <= 1'b0;
      b_resp_q <= sw_pkg::RESP_OKAY;
    end else if (wr_go) begin
      b_valid_q <= 1'b1;
      b_resp_q <= wr_map ? sw_pkg::RESP_OKAY : sw_pkg::RESP_SLVERR;
    end else if (bready) begin
      b_valid_q <= 1'b0;
    end
  end

  // =====================================================
  // command decode
  wire [15:0] key = w_data_q[sw_pkg::KEY_LSB +: 16];
  // half-word lanes needed, reserved upper bits ignored
  wire key_ok = wr_go && (wa == sw_pkg::OFF_KEY) && (w_strb_q[1:0] == 2'b11); // [R12]
  wire cmd_start = key_ok && (key == sw_pkg::KEY_START);
  wire cmd_reload = key_ok && (key == sw_pkg::KEY_RELOAD);
  wire cmd_unlock = key_ok && (key == sw_pkg::KEY_UNLOCK);
  wire cmd_other = key_ok && !cmd_unlock;
  logic unlock_q;
  wire wr_div = wr_go && unlock_q && (wa == sw_pkg::OFF_DIV); // [R7] [R19]
  wire wr_rld = wr_go && unlock_q && (wa == sw_pkg::OFF_RLD); // [R7] [R19]
  wire wr_win = wr_go && unlock_q && (wa == sw_pkg::OFF_WIN); // [R7] [R19]

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      unlock_q <= 1'b0;
    end else if (cmd_unlock) begin
      unlock_q <= 1'b1; // [R7]
    end else if (cmd_other) begin
      unlock_q <= 1'b0; // [R8]
    end
  end

  // =====================================================
  // low-speed oscillator tick, 40 khz from the 40 mhz clock
  logic [9:0] lso_cnt_q;
  wire lso_tick = (lso_cnt_q == sw_pkg::LSO_LAST); // [R14] [R15]
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lso_cnt_q <= 10'h000;
    end else begin
      lso_cnt_q <= lso_tick ? 10'h000 : lso_cnt_q + 10'h001;
    end
  end

  // =====================================================
  // shadow and active configuration, update busy bits
  sw_pkg::sw_cfg_t shd_q, act_q;
  logic [2:0] busy_q;
  logic [1:0] sync_q [3];
  wire [2:0] wr_set = {wr_win, wr_rld, wr_div};
  wire [31:0] div_m = merge({29'h0, shd_q.div}, w_data_q, w_strb_q);
  wire [31:0] rld_m = merge({20'h0, shd_q.reload_value}, w_data_q, w_strb_q);
  wire [31:0] win_m = merge({20'h0, shd_q.win}, w_data_q, w_strb_q);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shd_q <= '{win: sw_pkg::RST_WIN, reload_value: sw_pkg::RST_RLD, div: sw_pkg::RST_DIV};
    end else begin
      if (wr_div) shd_q.div <= div_m[sw_pkg::DIV_LSB +: 3];
      if (wr_rld) shd_q.reload_value <= rld_m[sw_pkg::RLD_LSB +: 12]; // [R16]
      if (wr_win) shd_q.win <= win_m[sw_pkg::WIN_LSB +: 12];
    end
  end

  // new write restarts the transfer, so a set beats a clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 3'h0;
      act_q <= '{win: sw_pkg::RST_WIN, reload_value: sw_pkg::RST_RLD, div: sw_pkg::RST_DIV};
      for (int i = 0; i < 3; i++) sync_q[i] <= 2'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_set[i]) begin
          busy_q[i] <= 1'b1; // [R9]
          sync_q[i] <= 2'h0;
        end else if (busy_q[i] && lso_tick) begin
          if (sync_q[i] == sw_pkg::SYNC_LAST) begin
            busy_q[i] <= 1'b0; // [R20]
          end
          sync_q[i] <= sync_q[i] + 2'h1;
        end
      end
      if (busy_q[0] && !wr_div && lso_tick && sync_q[0] == sw_pkg::SYNC_LAST) act_q.div <= shd_q.div;
      if (busy_q[1] && !wr_rld && lso_tick && sync_q[1] == sw_pkg::SYNC_LAST) act_q.reload_value <= shd_q.reload_value;
      if (busy_q[2] && !wr_win && lso_tick && sync_q[2] == sw_pkg::SYNC_LAST) act_q.win <= shd_q.win;
    end
  end

  // =====================================================
  // prescaler and down counter
  logic en_q, boot_q, rst_q;
  logic [7:0] pre_q;
  logic [11:0] cnt_q;
  wire run = en_q && !(core_debug_halt && debug_freeze); // [R10]
  wire pre_end = (pre_q == div_last(act_q.div)); // [R11]
  wire ctick = lso_tick && run && pre_end; // [R5]
  wire load = cmd_reload || (cmd_start && !en_q) || (!boot_q && auto_start_opt);
  wire win_bad = cmd_reload && en_q && (cnt_q > act_q.win); // [R18]

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pre_q <= 8'h00;
    end else if (load) begin
      pre_q <= 8'h00;
    end else if (lso_tick && run) begin
      pre_q <= pre_end ? 8'h00 : pre_q + 8'h01; // [R5]
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      boot_q <= 1'b0;
      en_q <= 1'b0;
      cnt_q <= sw_pkg::RST_RLD;
    end else begin
      boot_q <= 1'b1;
      if ((!boot_q && auto_start_opt) || cmd_start) begin
        en_q <= 1'b1; // [R1] [R6]
      end
      if (load) begin
        cnt_q <= act_q.reload_value; // [R3] [R4] [R21]
      end else if (ctick && cnt_q != 12'h000) begin
        cnt_q <= cnt_q - 12'h001; // [R1]
      end
    end
  end

  // held until the system reset takes effect
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_q <= 1'b0;
    end else if ((en_q && cnt_q == 12'h000) || win_bad) begin
      rst_q <= 1'b1; // [R2] [R18]
    end
  end

  // =====================================================
  // axi4-lite read channel
  logic ar_rdy_q, r_valid_q;
  logic [31:0] r_data_q;
  logic [1:0] r_resp_q;
  wire [7:0] ra = {araddr[7:2], 2'b00};
  wire ar_take = arvalid && ar_rdy_q;
  wire rd_map = mapped(ra);
  // busy registers read as zero; command reads zero
  wire [31:0] rd_val =
    (ra == sw_pkg::OFF_DIV && !busy_q[0]) ? {29'h0, shd_q.div} :
    (ra == sw_pkg::OFF_RLD && !busy_q[1]) ? {20'h0, shd_q.reload_value} :
    (ra == sw_pkg::OFF_WIN && !busy_q[2]) ? {20'h0, shd_q.win} :
    (ra == sw_pkg::OFF_STAT) ? {29'h0, busy_q} : 32'h0; // [R9] [R12] [R17]

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ar_rdy_q <= 1'b0;
      r_valid_q <= 1'b0;
      r_data_q <= 32'h0;
      r_resp_q <= sw_pkg::RESP_OKAY;
    end else begin
      ar_rdy_q <= arvalid && !ar_rdy_q && !r_valid_q;
      if (ar_take) begin
        r_valid_q <= 1'b1;
        r_data_q <= rd_val;
        r_resp_q <= rd_map ? sw_pkg::RESP_OKAY : sw_pkg::RESP_SLVERR;
      end else if (rready) begin
        r_valid_q <= 1'b0;
      end
    end
  end

  assign awready = aw_rdy_q;
  assign wready = w_rdy_q;
  assign bvalid = b_valid_q;
  assign bresp = b_resp_q;
  assign arready = ar_rdy_q;
  assign rvalid = r_valid_q;
  assign rdata = r_data_q;
  assign rresp = r_resp_q;
  assign system_reset_req = rst_q;
  assign watchdog_running = en_q;

  // =====================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_unlock_then_write;
    cmd_unlock ##[1:20] wr_div;
  endsequence
  start_load_a: assert property ((cmd_start && !en_q && !cmd_reload) |=> // [R21]
      (cnt_q == $past(act_q.reload_value)) && en_q)
    else $error("start did not load reload value");
  zero_reset_a: assert property ((en_q && cnt_q == 12'h000) |=> rst_q) // [R2]
    else $error("no reset at zero count");
  reload_val_a: assert property (cmd_reload |=> cnt_q == $past(act_q.reload_value)) // [R3]
    else $error("reload did not load counter");
  protect_wr_a: assert property ((wr_go && !unlock_q) |=> $stable(shd_q)) // [R19]
    else $error("protected write changed a value");
  relock_cmd_a: assert property (cmd_other |=> !unlock_q) // [R8]
    else $error("protection not restored");
  busy_set_a: assert property (s_unlock_then_write |=> busy_q[0] && unlock_q) // [R9]
    else $error("divider busy not set");
  debug_hold_a: assert property ((core_debug_halt && debug_freeze && !load) |=> // [R10]
      $stable(cnt_q) && $stable(pre_q))
    else $error("counter moved while frozen");
  div_wrap_a: assert property ((lso_tick && run && !load && pre_end) |=> pre_q == 8'h00) // [R11]
    else $error("prescaler wrapped at wrong count");
  window_rst_a: assert property (win_bad |=> rst_q) // [R18]
    else $error("window violation missed");
  lso_period_a: assert property (lso_tick |=> !lso_tick [*8]) // [R14]
    else $error("oscillator tick too frequent");
  busy_clear_a: assert property ((busy_q[1] && lso_tick && !wr_rld && // [R20]
      sync_q[1] == sw_pkg::SYNC_LAST) |=> !busy_q[1] && act_q.reload_value == shd_q.reload_value)
    else $error("reload busy did not clear");
endmodule

// *** test_standalone_watchdog_timer.sv ***
// self-checking bench of the standalone watchdog
`timescale 1ns/1ps
module test_standalone_watchdog_timer;
  // ==========================================
  // clock, ports and bookkeeping
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic auto_start_opt = 1'b0;
  logic core_debug_halt = 1'b0;
  logic debug_freeze = 1'b0;
  logic system_reset_req;
  logic watchdog_running;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [34:0] rq[$];
  logic [1:0] bq[$];
  logic [34:0] note;
  logic [31:0] rd_val;
  logic [2:0] code;
  logic [3:0] lanes = 4'hf;
  int n;

  always #12.5 clock = ~clock;

  sw_watchdog DUT (.clock(clock), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .auto_start_opt(auto_start_opt), .core_debug_halt(core_debug_halt),
    .debug_freeze(debug_freeze), .system_reset_req(system_reset_req),
    .watchdog_running(watchdog_running));

  // ==========================================
  // comparison and closing
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_total++;
      results();
    end
  end

  // ==========================================
  // monitor: oldest note against each answer
  always @(posedge clock) begin
    if (rvalid && rready) begin
      note = rq.pop_front();
      if (note[34]) begin
        check("rdata", rdata, note[31:0]);
        check("rresp", 32'(rresp), 32'(note[33:32]));
      end
    end
    if (bvalid && bready) begin
      check("bresp", 32'(bresp), 32'(bq.pop_front()));
    end
  end

  // ==========================================
  // bus and sequence tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= lanes;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bq.push_back(r);
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r,
                    input logic chk);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rq.push_back({chk, r, e});
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_val = rdata;
    rready <= 1'b0;
  endtask

  task automatic settle();
    rd_val = 32'h7;
    for (int i = 0; i < 40 && rd_val[2:0] != 3'h0; i++) begin
      repeat (100) @(posedge clock);
      rd(sw_pkg::OFF_STAT, 32'h0, sw_pkg::RESP_OKAY, 1'b0);
    end
    check("busy bits", rd_val, 32'h0);
  endtask

  task automatic rst_time(input int lo, input int hi);
    n = 0;
    while (!system_reset_req && n < hi + 10) begin
      @(posedge clock);
      n++;
    end
    check("reset request", 32'(system_reset_req), 32'h1);
    check("reset delay", 32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic power_up(input logic opt);
    @(posedge clock);
    nrst <= 1'b0;
    auto_start_opt <= opt;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
  endtask

  task automatic unlock();
    wr(sw_pkg::OFF_KEY, {16'($urandom()), sw_pkg::KEY_UNLOCK}, sw_pkg::RESP_OKAY);
  endtask

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h1531));
    power_up(1'b0);
    core_debug_halt <= 1'b1;
    rd(sw_pkg::OFF_KEY, 32'h0, sw_pkg::RESP_OKAY, 1'b1);
    rd(sw_pkg::OFF_DIV, 32'h0, sw_pkg::RESP_OKAY, 1'b1);
    rd(sw_pkg::OFF_RLD, 32'hfff, sw_pkg::RESP_OKAY, 1'b1);
    rd(sw_pkg::OFF_STAT, 32'h0, sw_pkg::RESP_OKAY, 1'b1);
    rd(sw_pkg::OFF_WIN, 32'hfff, sw_pkg::RESP_OKAY, 1'b1);
    rd(8'h14, 32'h0, sw_pkg::RESP_SLVERR, 1'b1);
    wr(8'h14, 32'h1, sw_pkg::RESP_SLVERR);
    // start key on the upper lanes only must be ignored
    lanes = 4'hc;
    wr(sw_pkg::OFF_KEY, {16'h0, sw_pkg::KEY_START}, sw_pkg::RESP_OKAY);
    lanes = 4'hf;
    check("running", 32'(watchdog_running), 32'h0);
    wr(sw_pkg::OFF_DIV, 32'h5, sw_pkg::RESP_OKAY);
    wr(sw_pkg::OFF_RLD, 32'h3, sw_pkg::RESP_OKAY);
    rd(sw_pkg::OFF_DIV, 32'h0, sw_pkg::RESP_OKAY, 1'b1);
    rd(sw_pkg::OFF_RLD, 32'hfff, sw_pkg::RESP_OKAY, 1'b1);
    unlock();
    code = 3'($urandom_range(7, 1));
    wr(sw_pkg::OFF_DIV, {29'h0, code}, sw_pkg::RESP_OKAY);
    rd(sw_pkg::OFF_STAT, 32'h1, sw_pkg::RESP_OKAY, 1'b1);
    rd(sw_pkg::OFF_DIV, 32'h0, sw_pkg::RESP_OKAY, 1'b1);
    settle();
    rd(sw_pkg::OFF_DIV, {29'h0, code}, sw_pkg::RESP_OKAY, 1'b1);
    wr(sw_pkg::OFF_KEY, 32'h1234, sw_pkg::RESP_OKAY);
    wr(sw_pkg::OFF_DIV, 32'h0, sw_pkg::RESP_OKAY);
    rd(sw_pkg::OFF_DIV, {29'h0, code}, sw_pkg::RESP_OKAY, 1'b1);
    // timeout through a reload, counting through debug halt
    unlock();
    wr(sw_pkg::OFF_DIV, 32'h0, sw_pkg::RESP_OKAY);
    n = $urandom_range(4, 2);
    wr(sw_pkg::OFF_RLD, 32'(n), sw_pkg::RESP_OKAY);
    settle();
    code = 3'(n);
    wr(sw_pkg::OFF_KEY, {16'h0, sw_pkg::KEY_START}, sw_pkg::RESP_OKAY);
    check("running", 32'(watchdog_running), 32'h1);
    repeat (int'(code) * 4000 - 2000) @(posedge clock);
    check("early reset", 32'(system_reset_req), 32'h0);
    wr(sw_pkg::OFF_KEY, {16'h0, sw_pkg::KEY_RELOAD}, sw_pkg::RESP_OKAY);
    rst_time(int'(code) * 4000 - 1010, int'(code) * 4000 + 10);
    // auto-start and window
    power_up(1'b1);
    repeat (2) @(posedge clock);
    check("auto start", 32'(watchdog_running), 32'h1);
    unlock();
    wr(sw_pkg::OFF_WIN, 32'h1, sw_pkg::RESP_OKAY);
    settle();
    check("early reset", 32'(system_reset_req), 32'h0);
    wr(sw_pkg::OFF_KEY, {16'h0, sw_pkg::KEY_RELOAD}, sw_pkg::RESP_OKAY);
    rst_time(0, 10);
    // freeze while halted
    power_up(1'b0);
    debug_freeze <= 1'b1;
    unlock();
    wr(sw_pkg::OFF_RLD, 32'h2, sw_pkg::RESP_OKAY);
    settle();
    wr(sw_pkg::OFF_KEY, {16'h0, sw_pkg::KEY_START}, sw_pkg::RESP_OKAY);
    repeat (12000) @(posedge clock);
    check("frozen reset", 32'(system_reset_req), 32'h0);
    core_debug_halt <= 1'b0;
    rst_time(6990, 8010);
    results();
  end
endmodule
